//--- hdl/qdu_pkg.sv
// Purpose: Shared constants and types of the quad DAC update slave.
// Assumes: 7-bit addressing, 8-bit codes, four channels.
// Notes: Load mode codes follow the control byte encoding.
package qdu_pkg;

  // ************************************************************
  // Address and byte framing
  // ************************************************************
  localparam logic [4:0] ADDR_PREFIX = 5'h13;
  localparam logic [6:0] BCAST_ADDR = 7'h48;
  localparam logic [4:0] HS_CODE_PREFIX = 5'h01;
  localparam int HS_CODE_LSB = 3;
  localparam int ADDR_RW_BIT = 0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ************************************************************
  // Control byte field positions
  // ************************************************************
  localparam int CTRL_EXT_HI = 7;
  localparam int CTRL_EXT_LO = 6;
  localparam int CTRL_LOAD_HI = 5;
  localparam int CTRL_LOAD_LO = 4;
  localparam int CTRL_CHAN_HI = 2;
  localparam int CTRL_CHAN_LO = 1;
  localparam int CTRL_PD = 0;

  // ************************************************************
  // Sizes, reset values, synchroniser lanes
  // ************************************************************
  localparam int NUM_CHAN = 4;
  localparam int CHAN_W = 2;
  localparam int CODE_W = 8;
  localparam logic [CODE_W-1:0] CODE_RST = 8'h00;
  localparam logic PD_RST = 1'b0;
  localparam logic [7:0] BYTE_RST = 8'h00;

  localparam int SYL_W = 8;
  localparam int SYL_RST = 0;
  localparam int SYL_CE = 1;
  localparam int SYL_SCL = 2;
  localparam int SYL_SDA = 3;
  localparam int SYL_DSH = 4;
  localparam int SYL_DSL = 5;
  localparam int SYL_EXH = 6;
  localparam int SYL_EXL = 7;
  localparam int SYM_W = 2;
  localparam int SYM_TGL = 0;
  localparam int SYM_HS = 1;

  typedef enum logic [1:0] {
    LOAD_TEMP = 2'h0,
    LOAD_ONE = 2'h1,
    LOAD_SYNC = 2'h2,
    LOAD_BCAST = 2'h3
  } qdu_load_e;

  typedef struct packed {
    qdu_load_e mode;
    logic [CHAN_W-1:0] chan;
    logic pd;
    logic [CODE_W-1:0] code;
  } qdu_upd_s;

  typedef logic [NUM_CHAN-1:0][CODE_W-1:0] qdu_bank_t;

endpackage : qdu_pkg

//--- hdl/qdu_sync.sv
// Purpose: Two-stage synchroniser for a vector of independent levels.
// Assumes: Each lane is a level; no lane relates to another.
// Notes: Not frozen by clock enable, so levels stay fresh.
`timescale 1ns/1ps
module qdu_sync #(
  parameter int W = 1
) (
  input logic clk,
  input logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_next;

  always_comb begin
    meta_next = d;
    q_next = meta_reg;
  end

  always_ff @(posedge clk) begin
    meta_reg <= meta_next;
    q <= q_next;
  end

endmodule : qdu_sync

//--- hdl/qdu_bank.sv
// Purpose: Temporary and output registers of the four channels.
// Assumes: upd_valid is a one-cycle pulse with upd stable around it.
// Notes: Outputs load one cycle after upd_valid.
`timescale 1ns/1ps
module qdu_bank (
  input logic mclk,
  input logic rst_n,
  input logic clk_en,
  input logic upd_valid,
  input qdu_pkg::qdu_upd_s upd,
  output qdu_pkg::qdu_bank_t dac_code,
  output logic [qdu_pkg::NUM_CHAN-1:0] chan_pd,
  output logic dac_load
);
  import qdu_pkg::*;

  logic load_reg;
  logic load_next;

  always_comb begin
    load_next = upd_valid && (upd.mode != LOAD_TEMP);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      load_reg <= 1'b0;
    end else if (clk_en) begin
      load_reg <= load_next;
    end
  end

  assign dac_load = load_reg;

  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
    logic hit;
    logic [CODE_W-1:0] tmp_reg, tmp_next, out_reg, out_next;
    logic tpd_reg, tpd_next, opd_reg, opd_next;

    assign hit = (upd.chan == CHAN_W'(c));

    always_comb begin
      tmp_next = tmp_reg;
      tpd_next = tpd_reg;
      out_next = out_reg;
      opd_next = opd_reg;
      if (upd_valid) begin
        case (upd.mode)
          LOAD_TEMP: begin
            if (hit) begin
              tmp_next = upd.code;
              tpd_next = upd.pd;
            end
          end
          LOAD_ONE, LOAD_SYNC: begin
            if (hit) begin
              tmp_next = upd.code;
              tpd_next = upd.pd;
              out_next = upd.code;
              opd_next = upd.pd;
            end else if (upd.mode == LOAD_SYNC) begin
              out_next = tmp_reg;
              opd_next = tpd_reg;
            end
          end
          default: begin
            if (upd.chan[CHAN_W-1]) begin
              tmp_next = upd.code;
              tpd_next = upd.pd;
              out_next = upd.code;
              opd_next = upd.pd;
            end else begin
              out_next = tmp_reg;
              opd_next = tpd_reg;
            end
          end
        endcase
      end
    end

    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        tmp_reg <= CODE_RST;
        tpd_reg <= PD_RST;
        out_reg <= CODE_RST;
        opd_reg <= PD_RST;
      end else if (clk_en) begin
        tmp_reg <= tmp_next;
        tpd_reg <= tpd_next;
        out_reg <= out_next;
        opd_reg <= opd_next;
      end
    end

    assign dac_code[c] = out_reg;
    assign chan_pd[c] = opd_reg;
  end

endmodule : qdu_bank

//--- hdl/qdu_slave_top.sv
// Purpose: Two-wire slave front end of a quad 8-bit DAC.
// Assumes: link_clk oversamples SCL and SDA by about 16x the bit rate.
// Notes: Bit logic on link_clk, channel bank on mclk, toggle crossing.
// Behaviour
// - Slave at standard, fast, high-speed rates
// - Only 7-bit addresses; no general call
// - Start is SDA fall while SCL high
// - Ack address only when it matches
// - Every byte followed by one ack bit
// - Stop is SDA rise; release and wait
// - Master code never acked, enters high speed
// - High speed until stop condition
// - Address, control, MSB, LSB; ack each
// - Update on SCL fall ending LSB ack
// - Control byte persists until resent
// - Back-to-back MSB/LSB pairs update again
// - Address is prefix, two straps, R/W
// - Strap pins captured once after reset
// - Broadcast address acked regardless of straps
// - Broadcast only for writes
// - Control byte field layout decode
// - Load modes temp, one, sync, broadcast
// - Extended address must match pins, except in broadcast load mode
// - Broadcast mode source chosen by channel field high bit
`timescale 1ns/1ps
module qdu_slave_top (
  input logic mclk,
  input logic rst_n,
  input logic clk_en,
  input logic link_clk,
  input logic scl_in,
  input logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input logic dev_sel_hi_pin,
  input logic dev_sel_lo_pin,
  input logic ext_addr_hi_pin,
  input logic ext_addr_lo_pin,
  output qdu_pkg::qdu_bank_t dac_code,
  output logic [qdu_pkg::NUM_CHAN-1:0] chan_pd,
  output logic dac_load,
  output logic hs_mode
);
  import qdu_pkg::*;
  // ************************************************************
  // Local types
  // ************************************************************
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_SKIP
  } qdu_lstate_e;
  typedef enum logic [1:0] {
    K_ADDR,
    K_CTRL,
    K_MSB,
    K_LSB
  } qdu_kind_e;
  // ************************************************************
  // Link side synchronisers
  // ************************************************************
  logic [SYL_W-1:0] lsync_d;
  logic [SYL_W-1:0] lsync_q;
  assign lsync_d[SYL_RST] = rst_n;
  assign lsync_d[SYL_CE] = clk_en;
  assign lsync_d[SYL_SCL] = scl_in;
  assign lsync_d[SYL_SDA] = sda_in;
  assign lsync_d[SYL_DSH] = dev_sel_hi_pin;
  assign lsync_d[SYL_DSL] = dev_sel_lo_pin;
  assign lsync_d[SYL_EXH] = ext_addr_hi_pin;
  assign lsync_d[SYL_EXL] = ext_addr_lo_pin;
  qdu_sync #(
    .W(SYL_W)
  ) u_lsync (
    .clk(link_clk),
    .d(lsync_d),
    .q(lsync_q)
  );

  logic lrst_n;
  logic lce;
  logic scl_s;
  logic sda_s;
  logic [1:0] ext_s;
  assign lrst_n = lsync_q[SYL_RST];
  assign lce = lsync_q[SYL_CE];
  assign scl_s = lsync_q[SYL_SCL];
  assign sda_s = lsync_q[SYL_SDA];
  assign ext_s = {lsync_q[SYL_EXH], lsync_q[SYL_EXL]};
  // ************************************************************
  // Link state
  // ************************************************************
  qdu_lstate_e st_reg, st_next;
  qdu_kind_e kind_reg, kind_next;
  logic scl_q_reg, scl_q_next;
  logic sda_q_reg, sda_q_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] msb_reg, msb_next;
  logic ack_reg, ack_next;
  logic rd_reg, rd_next;
  logic hs_reg, hs_next;
  logic [1:0] sel_lat_reg, sel_lat_next;
  logic strap_done_reg, strap_done_next;
  logic upd_tgl_reg, upd_tgl_next;
  qdu_upd_s upd_reg, upd_next;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic own_hit;
  logic bcast_hit;
  logic hs_code;
  logic upd_ok;
  // Edges seen at the oversampling rate
  assign scl_rise = !scl_q_reg && scl_s;
  assign scl_fall = scl_q_reg && !scl_s;
  assign start_det = scl_q_reg && scl_s && sda_q_reg && !sda_s;
  assign stop_det = scl_q_reg && scl_s && !sda_q_reg && sda_s;
  // 10-bit headers and general call never equal these
  assign own_hit = (shift_reg[7:1] == {ADDR_PREFIX, sel_lat_reg});
  assign bcast_hit = (shift_reg[7:1] == BCAST_ADDR)
                     && !shift_reg[ADDR_RW_BIT];
  assign hs_code = (shift_reg[7:HS_CODE_LSB] == HS_CODE_PREFIX);
  assign upd_ok = (ctrl_reg[CTRL_LOAD_HI:CTRL_LOAD_LO] == LOAD_BCAST)
                  || (ctrl_reg[CTRL_EXT_HI:CTRL_EXT_LO] == ext_s);

  always_comb begin
    st_next = st_reg;
    kind_next = kind_reg;
    scl_q_next = scl_s;
    sda_q_next = sda_s;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    ctrl_next = ctrl_reg;
    msb_next = msb_reg;
    ack_next = ack_reg;
    rd_next = rd_reg;
    hs_next = hs_reg;
    sel_lat_next = sel_lat_reg;
    strap_done_next = strap_done_reg;
    upd_tgl_next = upd_tgl_reg;
    upd_next = upd_reg;

    // Straps read once; later pin changes are ignored
    if (!strap_done_reg) begin
      sel_lat_next = {lsync_q[SYL_DSH], lsync_q[SYL_DSL]};
      strap_done_next = 1'b1;
    end

    if (stop_det) begin
      st_next = ST_IDLE;
      ack_next = 1'b0;
      hs_next = 1'b0;
    end else if (start_det) begin
      // Repeated start keeps high-speed state
      st_next = ST_RX;
      kind_next = K_ADDR;
      bit_cnt_next = 4'h0;
      ack_next = 1'b0;
    end else begin
      case (st_reg)
        ST_IDLE: begin
          st_next = ST_IDLE;
        end
        ST_RX: begin
          if (scl_rise && (bit_cnt_reg != BITS_PER_BYTE)) begin
            shift_next = {shift_reg[6:0], sda_s};
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end else if (scl_fall && (bit_cnt_reg == BITS_PER_BYTE)) begin
            case (kind_reg)
              K_ADDR: begin
                if (hs_code) begin
                  hs_next = 1'b1;
                  st_next = ST_SKIP;
                end else if (own_hit || bcast_hit) begin
                  ack_next = 1'b1;
                  rd_next = shift_reg[ADDR_RW_BIT];
                  st_next = ST_ACK;
                end else begin
                  st_next = ST_SKIP;
                end
              end
              K_CTRL: begin
                ctrl_next = shift_reg;
                ack_next = 1'b1;
                st_next = ST_ACK;
              end
              K_MSB: begin
                msb_next = shift_reg;
                ack_next = 1'b1;
                st_next = ST_ACK;
              end
              default: begin
                ack_next = 1'b1;
                st_next = ST_ACK;
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            ack_next = 1'b0;
            bit_cnt_next = 4'h0;
            st_next = ST_RX;
            case (kind_reg)
              K_ADDR: begin
                // No readback data: a read sees released SDA
                st_next = rd_reg ? ST_SKIP : ST_RX;
                kind_next = K_CTRL;
              end
              K_CTRL: begin
                kind_next = K_MSB;
              end
              K_MSB: begin
                kind_next = K_LSB;
              end
              default: begin
                kind_next = K_MSB;
                if (upd_ok) begin
                  upd_tgl_next = !upd_tgl_reg;
                  upd_next.mode = qdu_load_e'(ctrl_reg[CTRL_LOAD_HI:CTRL_LOAD_LO]);
                  upd_next.chan = ctrl_reg[CTRL_CHAN_HI:CTRL_CHAN_LO];
                  upd_next.pd = ctrl_reg[CTRL_PD];
                  upd_next.code = msb_reg;
                end
              end
            endcase
          end
        end
        ST_SKIP: begin
          st_next = ST_SKIP;
        end
        default: begin
          st_next = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      st_reg <= ST_IDLE;
      kind_reg <= K_ADDR;
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      bit_cnt_reg <= 4'h0;
      shift_reg <= BYTE_RST;
      ctrl_reg <= BYTE_RST;
      msb_reg <= BYTE_RST;
      ack_reg <= 1'b0;
      rd_reg <= 1'b0;
      hs_reg <= 1'b0;
      sel_lat_reg <= 2'h0;
      strap_done_reg <= 1'b0;
      upd_tgl_reg <= 1'b0;
      upd_reg <= '0;
    end else if (lce) begin
      st_reg <= st_next;
      kind_reg <= kind_next;
      scl_q_reg <= scl_q_next;
      sda_q_reg <= sda_q_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      ctrl_reg <= ctrl_next;
      msb_reg <= msb_next;
      ack_reg <= ack_next;
      rd_reg <= rd_next;
      hs_reg <= hs_next;
      sel_lat_reg <= sel_lat_next;
      strap_done_reg <= strap_done_next;
      upd_tgl_reg <= upd_tgl_next;
      upd_reg <= upd_next;
    end
  end

  // Open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe = ack_reg;
  // ************************************************************
  // Crossing to mclk
  // ************************************************************
  // upd_reg is held for a whole byte time after the toggle,
  // so it is stable until long after the synced toggle is seen.
  logic [SYM_W-1:0] msync_d;
  logic [SYM_W-1:0] msync_q;
  logic tgl_q_reg, tgl_q_next;
  logic upd_valid;

  assign msync_d[SYM_TGL] = upd_tgl_reg;
  assign msync_d[SYM_HS] = hs_reg;

  qdu_sync #(
    .W(SYM_W)
  ) u_msync (
    .clk(mclk),
    .d(msync_d),
    .q(msync_q)
  );

  always_comb begin
    tgl_q_next = msync_q[SYM_TGL];
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tgl_q_reg <= 1'b0;
    end else if (clk_en) begin
      tgl_q_reg <= tgl_q_next;
    end
  end

  assign upd_valid = clk_en && (msync_q[SYM_TGL] != tgl_q_reg);
  assign hs_mode = msync_q[SYM_HS];

  // ************************************************************
  // Channel bank
  // ************************************************************
  qdu_bank u_bank (
    .mclk(mclk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .upd_valid(upd_valid),
    .upd(upd_reg),
    .dac_code(dac_code),
    .chan_pd(chan_pd),
    .dac_load(dac_load)
  );

endmodule : qdu_slave_top

//--- tb/qdu_slave_top_monitor.sv
// Purpose: Port checker for qdu_slave_top.
// Assumes: SCL and SDA ports carry the wire levels.
// Notes: Link checks on link_clk, bank checks on mclk.
`timescale 1ns/1ps
module qdu_slave_top_monitor (
  input logic mclk,
  input logic rst_n,
  input logic link_clk,
  input logic scl_in,
  input logic sda_in,
  input logic sda_oe,
  input qdu_pkg::qdu_bank_t dac_code,
  input logic [qdu_pkg::NUM_CHAN-1:0] chan_pd,
  input logic dac_load,
  input logic hs_mode
);
  import qdu_pkg::*;
  // *****
  // Time since the last ack drive, in mclk
  // *****
  logic [4:0] since_oe_reg;
  logic [4:0] since_oe_next;
  always_comb begin
    since_oe_next = (since_oe_reg == 5'h1f) ? since_oe_reg : since_oe_reg + 5'h01;
    if (!rst_n || sda_oe) begin
      since_oe_next = rst_n ? 5'h00 : 5'h1f;
    end
  end
  always_ff @(posedge mclk) begin
    since_oe_reg <= since_oe_next;
  end

  sequence s_stop;
    scl_in && !sda_in ##1 scl_in && sda_in;
  endsequence
  property p_oe_moves_low;
    @(posedge link_clk) disable iff (!rst_n) $changed(sda_oe) |-> !scl_in && !$past(scl_in);
  endproperty
  property p_oe_steady_high;
    @(posedge link_clk) disable iff (!rst_n) scl_in && $past(scl_in) |-> $stable(sda_oe);
  endproperty
  property p_stop_hs;
    @(posedge link_clk) disable iff (!rst_n) s_stop |-> ##[1:16] !hs_mode;
  endproperty
  property p_hs_no_ack;
    @(posedge link_clk) disable iff (!rst_n) $rose(hs_mode) |-> !sda_oe && !$past(sda_oe);
  endproperty
  property p_load_pulse;
    @(posedge mclk) disable iff (!rst_n) dac_load |=> !dac_load;
  endproperty
  property p_code_load;
    @(posedge mclk) disable iff (!rst_n) $changed(dac_code) |-> dac_load;
  endproperty
  property p_pd_load;
    @(posedge mclk) disable iff (!rst_n) $changed(chan_pd) |-> dac_load;
  endproperty
  property p_load_after_ack;
    @(posedge mclk) disable iff (!rst_n) dac_load |-> since_oe_reg < 5'h10;
  endproperty
  a_oe_moves_low: assert property (p_oe_moves_low) else $error("ack moved in SCL high");
  a_oe_steady_high: assert property (p_oe_steady_high) else $error("ack not steady");
  a_stop_hs: assert property (p_stop_hs) else $error("stop kept high speed");
  a_hs_no_ack: assert property (p_hs_no_ack) else $error("master code acked");
  a_load_pulse: assert property (p_load_pulse) else $error("load longer than 1");
  a_code_load: assert property (p_code_load) else $error("code moved without load");
  a_pd_load: assert property (p_pd_load) else $error("pd moved without load");
  a_load_after_ack: assert property (p_load_after_ack) else $error("load not after ack");
endmodule : qdu_slave_top_monitor

bind qdu_slave_top qdu_slave_top_monitor u_mon (
  .mclk(mclk),
  .rst_n(rst_n),
  .link_clk(link_clk),
  .scl_in(scl_in),
  .sda_in(sda_in),
  .sda_oe(sda_oe),
  .dac_code(dac_code),
  .chan_pd(chan_pd),
  .dac_load(dac_load),
  .hs_mode(hs_mode)
);

//--- tb/qdu_bus_master.sv
// Purpose: Two-wire bus master model.
// Assumes: SDA has a pull-up; this model only pulls low.
// Notes: Bit time 1024 ns, well over 3 link_clk per phase.
`timescale 1ns/1ps
module qdu_bus_master (
  output logic scl,
  output logic sda_drv,
  input logic sda_wire
);
  localparam time HALF = 512ns;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // *****
  // Conditions; full low phase lets the slave release first
  // *****
  task automatic bus_start;
    sda_drv = 1'b1;
    #(HALF);
    scl = 1'b1;
    #(HALF);
    sda_drv = 1'b0;
    #(HALF);
    scl = 1'b0;
    #(HALF/2);
  endtask : bus_start
  task automatic bus_stop;
    sda_drv = 1'b0;
    #(HALF);
    scl = 1'b1;
    #(HALF);
    sda_drv = 1'b1;
    #(HALF);
  endtask : bus_stop
  task automatic bus_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_drv = b[i];
      #(HALF/2);
      scl = 1'b1;
      #(HALF);
      scl = 1'b0;
      #(HALF/2);
    end
    sda_drv = 1'b1;
    #(HALF/2);
    scl = 1'b1;
    #(HALF/2);
    ack = ~sda_wire;
    #(HALF/2);
    scl = 1'b0;
    #(HALF/2);
  endtask : bus_byte
endmodule : qdu_bus_master

//--- tb/qdu_slave_top_tb_top.sv
// Purpose: Self-checking bench for qdu_slave_top.
// Assumes: Straps dev_sel 10, ext pins 10.
// Notes: Update frames driven through the master model.
`timescale 1ns/1ps
module qdu_slave_top_tb_top;
  import qdu_pkg::*;
  logic mclk, rst_n, link_clk, scl, sda_drv, sda_wire, sda_out, sda_oe;
  logic dac_load, hs_mode, ack, ce;
  logic [3:0] pins;
  qdu_bank_t dac_code;
  logic [NUM_CHAN-1:0] chan_pd;
  logic [7:0] bad [5] = '{8'h98, 8'h00, 8'h91, 8'hf0, 8'h9a};
  int error_cnt = 0;
  int checked = 0;
  int loads = 0;
  int l0;
  // Pull-up wire: low if either party pulls
  assign sda_wire = sda_drv & ~(sda_oe & ~sda_out);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #32 link_clk = ~link_clk;
  end
  always @(posedge mclk) if (dac_load === 1'b1) loads++;

  qdu_slave_top dut (.mclk(mclk), .rst_n(rst_n), .clk_en(ce), .link_clk(link_clk),
    .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
    .dev_sel_hi_pin(pins[3]), .dev_sel_lo_pin(pins[2]), .ext_addr_hi_pin(pins[1]),
    .ext_addr_lo_pin(pins[0]), .dac_code(dac_code), .chan_pd(chan_pd),
    .dac_load(dac_load), .hs_mode(hs_mode));
  qdu_bus_master m (.scl(scl), .sda_drv(sda_drv), .sda_wire(sda_wire));

  // *****
  // Tasks
  // *****
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask : chk
  task automatic xfer(input logic [7:0] b, input logic exp);
    m.bus_byte(b, ack);
    chk(32'(ack), 32'(exp));
  endtask : xfer
  task automatic upd(input logic [7:0] adr, ctl, msb, input int n, input logic exp, hs);
    logic [7:0] d;
    d = msb;
    m.bus_start();
    if (hs) begin
      xfer(8'h09, 1'b0);
      #1000;
      chk(32'(hs_mode), 32'h1);
      m.bus_start();
    end
    xfer(adr, exp);
    xfer(ctl, exp);
    for (int i = 0; i < n; i++) begin
      xfer(d, exp);
      xfer(~d, exp);
      d = ~d;
    end
    m.bus_stop();
    #2000;
  endtask : upd
  task automatic final_report;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  // *****
  // Tests
  // *****
  initial begin
    #3ms;
    error_cnt++;
    final_report();
  end
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    pins = 4'b1010;
    repeat (12) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (20) @(posedge mclk);
    chk(32'(dac_code), 32'h0000_0000);
    l0 = loads;
    upd(8'h9c, 8'h94, 8'ha5, 2, 1'b1, 1'b0);
    chk(32'(dac_code), 32'h005a_0000);
    chk(loads - l0, 32'h2);
    // Straps were taken at reset; later pin levels must not count
    pins[3:2] = 2'b01;
    foreach (bad[i]) begin
      upd(bad[i], 8'h94, 8'h11, 1, 1'b0, 1'b0);
    end
    l0 = loads;
    upd(8'h90, 8'h14, 8'h11, 1, 1'b1, 1'b0);
    upd(8'h9c, 8'h82, 8'h77, 1, 1'b1, 1'b0);
    chk(32'(dac_code), 32'h005a_0000);
    chk(loads - l0, 32'h0);
    upd(8'h9c, 8'ha0, 8'h33, 1, 1'b1, 1'b0);
    chk(32'(dac_code), 32'h005a_7733);
    upd(8'h9c, 8'h86, 8'h44, 1, 1'b1, 1'b0);
    upd(8'h90, 8'h30, 8'h99, 1, 1'b1, 1'b0);
    chk(32'(dac_code), 32'h445a_7733);
    upd(8'h90, 8'h35, 8'hc3, 1, 1'b1, 1'b0);
    chk(32'(dac_code), 32'hc3c3_c3c3);
    chk(32'(chan_pd), 32'hf);
    // Frozen block: frame is lost, no ack, no update
    @(posedge mclk);
    #1 ce = 1'b0;
    upd(8'h9c, 8'h94, 8'hee, 1, 1'b0, 1'b0);
    @(posedge mclk);
    #1 ce = 1'b1;
    chk(32'(dac_code), 32'hc3c3_c3c3);
    upd(8'h9c, 8'h92, 8'h12, 1, 1'b1, 1'b1);
    chk(32'(dac_code), 32'hc3c3_12c3);
    chk(32'(chan_pd), 32'hd);
    chk(32'(hs_mode), 32'h0);
    final_report();
  end
endmodule : qdu_slave_top_tb_top
